// *** rtl/ctrl_byte.sv ***
/*
  One host-writable control byte with synchronous clear.
  Assumes the caller qualifies the write enable (address and lock).
*/
`timescale 1ns/1ns
`include "freq_ctrl_cfg.svh"

module ctrl_byte
    import freq_ctrl_pkg::*;
#(
    parameter int           WIDTH = 8,
    parameter [WIDTH-1:0]   RESET = `RESET_BYTE
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    input  wire logic             wr_en,
    input  wire logic [WIDTH-1:0] wr_data,
    output logic      [WIDTH-1:0] value_reg
);

    logic [WIDTH-1:0] value_next;

    always_comb begin
        value_next = value_reg;
        if (wr_en) begin
            value_next = wr_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            value_reg <= RESET;
        end else begin
            value_reg <= value_next;
        end
    end

endmodule // ctrl_byte

// *** rtl/freq_ctrl_cfg.svh ***
/*
  Offsets, field positions and reset values of the CPU frequency,
  programmed frequency and recovery frequency control bytes.
  Assumes it is included by bare name after the types package.
*/
`ifndef FREQ_CTRL_CFG_SVH
`define FREQ_CTRL_CFG_SVH

`define OFS_RECOVERY_SRC_M  8'h0c
`define OFS_CPU_N_VALUE     8'h0d
`define OFS_PROG_EN_CPU_M   8'h0e

`define BIT_RECOVERY_SEL    7
`define BIT_PROG_ENABLE     7
`define M_FIELD_MSB         6

`define RESET_BYTE          8'h00
`define READ_UNMAPPED       8'h00

`endif

// *** rtl/freq_ctrl_pkg.sv ***
/*
  Types shared by the frequency control register block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package freq_ctrl_pkg;

    // Byte access as delivered by the serial management bus front end
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] data;
    } host_req_s;

    // Setting handed to the synthesizer core
    typedef struct packed {
        logic       use_prog;
        logic [7:0] n_value;
        logic [6:0] m_value;
        logic [4:0] ratio_code;
    } freq_set_s;

    typedef enum logic [1:0] {
        MODE_NORMAL   = 2'b01,
        MODE_RECOVERY = 2'b10
    } freq_mode_e;

endpackage

// *** rtl/freq_ctrl_regs.sv ***
/*
  Control bytes that pick the CPU output frequency: programmed N and M,
  recovery source and recovery M (recovery N is the CPU N byte), strap or software ratio code,
  and the watchdog recovery lock.
  Assumes a bus front end that delivers one-cycle byte read and write
  strobes, and a watchdog that pulses on time-out; all inputs are
  synchronous to clk_sys.
*/
// Notes on behaviour
// R1 - The recovery source bit picks the strap code when clear and the recovery N and M when set.
// R2 - A watchdog time-out switches the output to the recovery frequency without software.
// R3 - Recovery N is eight bits and recovery M is seven bits below the source bit.
// R4 - Outside recovery the ratio code is the strap code unless the override bit selects the software code.
// R5 - Bit 7 of the CPU M byte enables programmed frequencies when set.
// R6 - With that enable set the CPU frequency comes from the CPU N and M bytes.
// R7 - Each write of the CPU M field starts loading the new frequency, so N goes first.
// R8 - All three bytes clear to zero at reset.
// R9 - After a time-out writes that change the frequency are ignored until the watchdog enable is cleared.
`timescale 1ns/1ns
`include "freq_ctrl_cfg.svh"

module freq_ctrl_regs
    import freq_ctrl_pkg::*;
(
    input  wire logic      clk_sys,
    input  wire logic      rst_b,
    input  wire host_req_s host_req,
    input  wire logic [4:0] latched_strap_code,
    input  wire logic [4:0] sel_code,
    input  wire logic      strap_override,
    input  wire logic      watchdog_enable,
    input  wire logic      watchdog_timeout,
    output logic [7:0]     rd_data_reg,
    output logic           rd_valid_reg,
    output freq_set_s      freq_set_reg,
    output logic           freq_load_reg,
    output logic           recovery_active_reg
);

    freq_mode_e mode_reg;
    freq_mode_e mode_next;
    logic [7:0] rec_byte;
    logic [7:0] cpu_n_byte;
    logic [7:0] cpu_m_byte;
    logic       wr_rec;
    logic       wr_cpu_n;
    logic       wr_cpu_m;
    logic       locked;
    logic       load_pend_reg;
    logic       load_pend_next;
    logic [7:0] rd_data_next;
    freq_set_s  freq_set_next;
    logic       enter_recovery;

    assign locked = (mode_reg == MODE_RECOVERY);

    // Whole-byte decode; a locked device drops frequency writes silently
    always_comb begin
        wr_rec   = 1'b0;
        wr_cpu_n = 1'b0;
        wr_cpu_m = 1'b0;
        if (!host_req.wr || locked) begin // R9
            wr_rec = 1'b0;
        end else if (host_req.addr == `OFS_RECOVERY_SRC_M) begin
            wr_rec = 1'b1;
        end else if (host_req.addr == `OFS_CPU_N_VALUE) begin
            wr_cpu_n = 1'b1;
        end else if (host_req.addr == `OFS_PROG_EN_CPU_M) begin
            wr_cpu_m = 1'b1;
        end
    end

    ctrl_byte #(.WIDTH(8), .RESET(`RESET_BYTE)) u_rec_byte ( // R8
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .wr_en     (wr_rec),
        .wr_data   (host_req.data),
        .value_reg (rec_byte)
    );

    ctrl_byte #(.WIDTH(8), .RESET(`RESET_BYTE)) u_cpu_n_byte (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .wr_en     (wr_cpu_n),
        .wr_data   (host_req.data),
        .value_reg (cpu_n_byte)
    );

    ctrl_byte #(.WIDTH(8), .RESET(`RESET_BYTE)) u_cpu_m_byte (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .wr_en     (wr_cpu_m),
        .wr_data   (host_req.data),
        .value_reg (cpu_m_byte)
    );

    // Time-out only counts while the watchdog is enabled
    assign enter_recovery = watchdog_timeout && watchdog_enable;

    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            MODE_NORMAL: begin
                if (enter_recovery) begin
                    mode_next = MODE_RECOVERY; // R2
                end
            end
            MODE_RECOVERY: begin
                if (!watchdog_enable) begin
                    mode_next = MODE_NORMAL; // R9
                end
            end
            default: begin
                mode_next = MODE_NORMAL;
            end
        endcase
    end

    // Setting is built from the stored bytes, so it trails a write by one
    always_comb begin
        freq_set_next = '0;
        if (locked) begin
            if (rec_byte[`BIT_RECOVERY_SEL]) begin // R1
                freq_set_next.use_prog = 1'b1;
                // Recovery N has no byte of its own here; it shares CPU N
                freq_set_next.n_value  = cpu_n_byte; // R3
                freq_set_next.m_value  = rec_byte[`M_FIELD_MSB:0]; // R3
            end
            freq_set_next.ratio_code = latched_strap_code; // R1
        end else begin
            freq_set_next.use_prog = cpu_m_byte[`BIT_PROG_ENABLE]; // R5
            freq_set_next.n_value  = cpu_n_byte; // R6
            freq_set_next.m_value  = cpu_m_byte[`M_FIELD_MSB:0]; // R6
            freq_set_next.ratio_code = strap_override ? sel_code
                                                      : latched_strap_code; // R4
        end
    end

    always_comb begin
        load_pend_next = wr_cpu_m; // R7
        rd_data_next   = `READ_UNMAPPED;
        if (host_req.addr == `OFS_RECOVERY_SRC_M) begin
            rd_data_next = rec_byte;
        end else if (host_req.addr == `OFS_CPU_N_VALUE) begin
            rd_data_next = cpu_n_byte;
        end else if (host_req.addr == `OFS_PROG_EN_CPU_M) begin
            rd_data_next = cpu_m_byte;
        end
        if (!host_req.rd) begin
            rd_data_next = rd_data_reg;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            mode_reg            <= MODE_NORMAL;
            load_pend_reg       <= 1'b0;
            freq_set_reg        <= '0;
            freq_load_reg       <= 1'b0;
            recovery_active_reg <= 1'b0;
            rd_data_reg         <= `RESET_BYTE;
            rd_valid_reg        <= 1'b0;
        end else begin
            mode_reg            <= mode_next;
            load_pend_reg       <= load_pend_next;
            freq_set_reg        <= freq_set_next;
            // Entering recovery reloads the synthesizer just like an M write
            freq_load_reg       <= load_pend_reg ||
                                   (locked && !recovery_active_reg); // R2 R7
            recovery_active_reg <= locked;
            rd_data_reg         <= rd_data_next;
            rd_valid_reg        <= host_req.rd;
        end
    end

    chk_src_strap: assert property (@(posedge clk_sys) disable iff (!rst_b) // R1
        (locked && !rec_byte[`BIT_RECOVERY_SEL]) |=>
        (!freq_set_reg.use_prog &&
         freq_set_reg.ratio_code == $past(latched_strap_code)))
        else $error("recovery from strap code not applied");

    chk_src_prog: assert property (@(posedge clk_sys) disable iff (!rst_b) // R3
        (locked && rec_byte[`BIT_RECOVERY_SEL]) |=>
        (freq_set_reg.use_prog &&
         freq_set_reg.m_value == $past(rec_byte[6:0])))
        else $error("programmed recovery values not applied");

    chk_wd_entry: assert property (@(posedge clk_sys) disable iff (!rst_b) // R2
        (!locked && enter_recovery) |=> ##1
        (recovery_active_reg && freq_load_reg))
        else $error("time-out did not enter recovery with reload");

    chk_ratio_sel: assert property (@(posedge clk_sys) disable iff (!rst_b) // R4
        (!locked && strap_override) |=>
        freq_set_reg.ratio_code == $past(sel_code))
        else $error("software ratio code not used under override");

    chk_prog_en: assert property (@(posedge clk_sys) disable iff (!rst_b) // R5
        !locked |=> freq_set_reg.use_prog == $past(cpu_m_byte[7]))
        else $error("programmed enable not followed");

    chk_prog_nm: assert property (@(posedge clk_sys) disable iff (!rst_b) // R6
        !locked |=> (freq_set_reg.n_value == $past(cpu_n_byte) &&
                     freq_set_reg.m_value == $past(cpu_m_byte[6:0])))
        else $error("programmed N or M not followed");

    chk_m_load: assert property (@(posedge clk_sys) disable iff (!rst_b) // R7
        wr_cpu_m |-> ##2 (freq_load_reg &&
        freq_set_reg.m_value == $past(host_req.data[6:0], 2)))
        else $error("M write did not start a load");

    chk_reset_zero: assert property (@(posedge clk_sys) // R8
        !rst_b |=> (rec_byte == 8'h00 && cpu_n_byte == 8'h00 &&
                    cpu_m_byte == 8'h00 && !recovery_active_reg))
        else $error("control bytes not cleared by reset");

    chk_lock_hold: assert property (@(posedge clk_sys) disable iff (!rst_b) // R9
        (locked && host_req.wr) |=> ($stable(cpu_n_byte) &&
        $stable(cpu_m_byte) && $stable(rec_byte)))
        else $error("write accepted during recovery lock");

    chk_lock_exit: assert property (@(posedge clk_sys) disable iff (!rst_b) // R9
        locked |=> (locked == $past(watchdog_enable)))
        else $error("recovery lock left or held wrongly");

endmodule // freq_ctrl_regs

// *** testbench/host_model.sv ***
/*
  Host side of the register request port: byte write and read cycles.
  Assumes the bench calls its tasks and a 25 MHz clk_sys.
*/
`timescale 1ns/1ns

module host_model
    import freq_ctrl_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic [7:0] rd_data_reg,
    input  wire logic       rd_valid_reg,
    output host_req_s       host_req
);
    initial host_req = '{wr: 1'b0, rd: 1'b0, addr: 8'hff, data: 8'hff};

    // Released address and data lines flip, so a stale value is never taken for data
    task automatic release_bus();
        host_req.wr   = 1'b0;
        host_req.rd   = 1'b0;
        host_req.addr = ~host_req.addr;
        host_req.data = ~host_req.data;
    endtask

    // Callers put the N byte ahead of the M byte
    task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        host_req = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
        @(negedge clk_sys);
        release_bus();
    endtask

    task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
        int i;
        @(negedge clk_sys);
        host_req = '{wr: 1'b0, rd: 1'b1, addr: a, data: host_req.data};
        @(negedge clk_sys);
        release_bus();
        for (i = 0; i < 4 && rd_valid_reg !== 1'b1; i++)
            @(negedge clk_sys);
        d = (rd_valid_reg === 1'b1) ? rd_data_reg : 8'hxx;
    endtask
endmodule // host_model

// *** testbench/testbench.sv ***
/*
  Self-checking bench for the frequency control bytes.
  Assumes the host model for bus cycles; inputs change at falling edges.
*/
`timescale 1ns/1ns

module testbench
    import freq_ctrl_pkg::*;
;
    logic       clk_sys;
    logic       rst_b;
    logic       strap_override;
    logic       watchdog_enable;
    logic       watchdog_timeout;
    logic [4:0] latched_strap_code;
    logic [4:0] sel_code;
    host_req_s  host_req;
    logic [7:0] rd_data_reg;
    logic [7:0] rd;
    logic       rd_valid_reg;
    logic       freq_load_reg;
    logic       recovery_active_reg;
    freq_set_s  freq_set_reg;
    int         n_errors = 0;
    int         checked = 0;

    freq_ctrl_regs u_dut (.clk_sys, .rst_b, .host_req, .latched_strap_code,
        .sel_code, .strap_override, .watchdog_enable, .watchdog_timeout,
        .rd_data_reg, .rd_valid_reg, .freq_set_reg, .freq_load_reg,
        .recovery_active_reg);
    host_model u_host (.clk_sys, .rd_data_reg, .rd_valid_reg, .host_req);

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checked=%0d errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        u_host.read_byte(a, rd);
        check(rd, e);
    endtask

    // Returns while the reload pulse of the time-out still stands
    task automatic pulse_timeout();
        watchdog_enable = 1'b1;
        @(negedge clk_sys);
        watchdog_timeout = 1'b1;
        @(negedge clk_sys);
        watchdog_timeout = 1'b0;
        @(negedge clk_sys);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    initial begin
        #40000;
        n_errors++;
        stop_test();
    end

    initial begin
        rst_b = 1'b0;
        strap_override = 1'b0;
        watchdog_enable = 1'b0;
        watchdog_timeout = 1'b0;
        latched_strap_code = 5'h0a;
        sel_code = 5'h13;
        repeat (5) @(negedge clk_sys);
        rst_b = 1'b1;
        check({freq_set_reg, freq_load_reg, recovery_active_reg}, '0);
        rd_chk(8'h0c, 8'h00);
        rd_chk(8'h0d, 8'h00);
        rd_chk(8'h0e, 8'h00);
        rd_chk(8'h0f, 8'h00);
        u_host.write_byte(8'h0d, 8'ha5);
        u_host.write_byte(8'h0e, 8'hbc);
        check(freq_load_reg, 1'b0);
        @(negedge clk_sys);
        check(freq_load_reg, 1'b1);
        check(freq_set_reg, {1'b1, 8'ha5, 7'h3c, 5'h0a});
        rd_chk(8'h0e, 8'hbc);
        strap_override = 1'b1;
        repeat (2) @(negedge clk_sys);
        check(freq_set_reg.ratio_code, 5'h13);
        u_host.write_byte(8'h0e, 8'h3c);
        repeat (2) @(negedge clk_sys);
        check(freq_set_reg.use_prog, 1'b0);
        u_host.write_byte(8'h0c, 8'h95);
        pulse_timeout();
        check({recovery_active_reg, freq_load_reg}, 2'b11);
        check(freq_set_reg, {1'b1, 8'ha5, 7'h15, 5'h0a});
        u_host.write_byte(8'h0d, 8'h11);
        rd_chk(8'h0d, 8'ha5);
        watchdog_enable = 1'b0;
        repeat (3) @(negedge clk_sys);
        check(recovery_active_reg, 1'b0);
        u_host.write_byte(8'h0c, 8'h15);
        rd_chk(8'h0c, 8'h15);
        pulse_timeout();
        check({freq_set_reg.use_prog, freq_set_reg.ratio_code}, 6'h0a);
        stop_test();
    end
endmodule // testbench
